//--- verilog/sadc_pkg.sv
package sadc_pkg;
   // Data-space addresses of the two converter registers
   localparam logic [7:0] RESULT_ADDR = 8'hD0;
   localparam logic [7:0] CTRL_ADDR = 8'hD1;
   // Control register field positions
   localparam int IRQ_EN_BIT = 7;
   localparam int DONE_BIT = 6;
   localparam int TRIG_BIT = 5;
   localparam int POWER_BIT = 4;
   localparam int CLKSEL_BIT = 2;
   localparam logic [7:0] CTRL_RESET = 8'h40;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   // Converter clock dividers
   localparam int DIV_FAST = 6;
   localparam int DIV_SLOW = 12;
   // Typical conversion times with the reference oscillator
   localparam int CONV_FAST_NS = 35000;
   localparam int CONV_SLOW_NS = 70000;
   localparam int OSC_KHZ = 8000;
   // Converter-clock periods per conversion, nearest whole count
   localparam int CONV_TICKS =
      (CONV_FAST_NS * OSC_KHZ / 1000000 + DIV_FAST / 2) / DIV_FAST;
   localparam int RES_BITS = 8;
   localparam int SAR_FIRST = CONV_TICKS - RES_BITS;
   typedef enum logic {SADC_IDLE, SADC_CONV} sadc_state_t;
endpackage

//--- verilog/sadc_tick_div.sv
`timescale 1ns/1ns
`default_nettype none
module sadc_tick_div (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic clr_i,
   input wire logic fast_i,
   output logic tick_o
);
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   wire logic [3:0] last_w;

   // Divide by 6 or 12; the clear realigns phase at each start
   assign last_w = fast_i ? 4'(sadc_pkg::DIV_FAST - 1)
                          : 4'(sadc_pkg::DIV_SLOW - 1);
   assign tick_o = (cnt_r >= last_w) && !clr_i;
   assign cnt_nxt = (clr_i || cnt_r >= last_w) ? 4'h0 : cnt_r + 4'h1;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) cnt_r <= 4'h0;
      else cnt_r <= cnt_nxt;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   property p_tick_gap;
      tick_o |=> !tick_o [*5];
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("converter clock ticks closer than six cycles");
endmodule // sadc_tick_div
`default_nettype wire

//--- verilog/sadc_control.sv
// What this block does
// - Writing trigger one starts a conversion if power is one, and clears the done flag.
// - Finishing a conversion sets done, meaning result holds valid data.
// - One conversion per trigger write; never restarts on its own.
// - Trigger written during a conversion abandons it, and restarts it if power is one.
// - Trigger bit 5 is write-only and always reads zero.
// - Interrupt request follows done, masked when bit 7 is zero.
// - Done flag bit 6 is read-only, cleared only by trigger writes.
// - Power bit 4 enables converter; zero idles and powers it down.
// - Reset stops conversion, loads control with 40h, masks interrupt.
// - Clock-select bit 2: one divides by 6, zero divides by 12.
// - At 8 MHz, 35 us with divide-by-6, 70 us with divide-by-12.
// - Result found by successive approximation, MSB first, 8 bits.
// - Result kept in result register; control register holds settings.
// - Result register is read-only at data address 0D0h.
`timescale 1ns/1ns
`default_nettype none
module sadc_control (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] bus_addr_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   output logic [7:0] bus_rdata_o,
   input wire logic cmp_above_i,
   output logic [7:0] dac_code_o,
   output logic converter_power_on_o,
   output logic conv_busy_o,
   output logic irq_o
);
   sadc_pkg::sadc_state_t state_r;
   sadc_pkg::sadc_state_t state_nxt;
   logic done_irq_enable_r;
   logic done_r;
   logic done_nxt;
   logic converter_power_on_r;
   logic clock_divider_select_r;
   logic [5:0] step_r;
   logic [5:0] step_nxt;
   logic [7:0] trial_r;
   logic [7:0] trial_nxt;
   logic [7:0] result_r;
   logic [7:0] rdata_r;
   wire logic tick_w;
   wire logic ctrl_wr_w;
   wire logic start_w;
   wire logic stop_w;
   wire logic last_w;
   wire logic sar_step_w;
   wire logic [2:0] bit_idx_w;
   wire logic [7:0] ctrl_rd_w;
   wire logic [7:0] rd_mux_w;

   // Register decode; a trigger with power off clears done and aborts, never starts
   assign ctrl_wr_w = bus_wr_i && bus_addr_i == sadc_pkg::CTRL_ADDR;
   assign start_w = ctrl_wr_w && bus_wdata_i[sadc_pkg::TRIG_BIT]
      && bus_wdata_i[sadc_pkg::POWER_BIT];
   assign stop_w = ctrl_wr_w && !bus_wdata_i[sadc_pkg::POWER_BIT];
   assign last_w = step_r == 6'(sadc_pkg::CONV_TICKS - 1);
   assign sar_step_w = state_r == sadc_pkg::SADC_CONV && tick_w
      && step_r >= 6'(sadc_pkg::SAR_FIRST);
   assign bit_idx_w = 3'(sadc_pkg::CONV_TICKS - 1 - int'(step_r));

   sadc_tick_div u_div (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .clr_i(start_w),
      .fast_i(clock_divider_select_r),
      .tick_o(tick_w)
   );

   // Sequencer: restart wins over everything, power-off aborts
   always_comb begin
      state_nxt = state_r;
      step_nxt = step_r;
      trial_nxt = trial_r;
      done_nxt = done_r;
      if (start_w) begin
         state_nxt = sadc_pkg::SADC_CONV;
         step_nxt = 6'h00;
         trial_nxt = 8'h80;
         done_nxt = 1'b0;
      end else if (ctrl_wr_w && bus_wdata_i[sadc_pkg::TRIG_BIT]) begin
         // Trigger with power off still powers down, so abort too
         state_nxt = sadc_pkg::SADC_IDLE;
         done_nxt = 1'b0;
      end else begin
         case (state_r)
            sadc_pkg::SADC_IDLE: begin
               state_nxt = sadc_pkg::SADC_IDLE;
            end
            sadc_pkg::SADC_CONV: begin
               if (stop_w) begin
                  state_nxt = sadc_pkg::SADC_IDLE;
               end else if (tick_w) begin
                  step_nxt = step_r + 6'h01;
                  if (last_w) begin
                     state_nxt = sadc_pkg::SADC_IDLE;
                     done_nxt = 1'b1;
                  end
               end
            end
            default: state_nxt = sadc_pkg::SADC_IDLE;
         endcase
      end
      // Decide one bit, then try the next lower one
      if (sar_step_w && !start_w && !stop_w) begin
         trial_nxt[bit_idx_w] = cmp_above_i;
         if (bit_idx_w != 3'h0) trial_nxt[bit_idx_w - 3'h1] = 1'b1;
      end
   end

   // Sequencer state and result capture
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_r <= sadc_pkg::SADC_IDLE;
         step_r <= 6'h00;
         trial_r <= 8'h00;
         done_r <= sadc_pkg::CTRL_RESET[sadc_pkg::DONE_BIT];
         result_r <= sadc_pkg::RESULT_RESET;
      end else begin
         state_r <= state_nxt;
         step_r <= step_nxt;
         trial_r <= trial_nxt;
         done_r <= done_nxt;
         if (state_r == sadc_pkg::SADC_CONV && state_nxt ==
             sadc_pkg::SADC_IDLE && done_nxt) begin
            result_r <= trial_nxt;
         end
      end
   end

   // Writable control bits; done and trigger are not stored here
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         done_irq_enable_r <= sadc_pkg::CTRL_RESET[sadc_pkg::IRQ_EN_BIT];
         converter_power_on_r <= sadc_pkg::CTRL_RESET[sadc_pkg::POWER_BIT];
         clock_divider_select_r <=
            sadc_pkg::CTRL_RESET[sadc_pkg::CLKSEL_BIT];
      end else if (ctrl_wr_w) begin
         done_irq_enable_r <= bus_wdata_i[sadc_pkg::IRQ_EN_BIT];
         converter_power_on_r <= bus_wdata_i[sadc_pkg::POWER_BIT];
         clock_divider_select_r <= bus_wdata_i[sadc_pkg::CLKSEL_BIT];
      end
   end

   // Read path; trigger and reserved bits read as zero
   assign ctrl_rd_w = {done_irq_enable_r, done_r, 1'b0,
      converter_power_on_r, 1'b0, clock_divider_select_r, 2'b00};
   assign rd_mux_w = bus_addr_i == sadc_pkg::CTRL_ADDR ? ctrl_rd_w
      : bus_addr_i == sadc_pkg::RESULT_ADDR ? result_r : 8'h00;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) rdata_r <= 8'h00;
      else if (bus_rd_i) rdata_r <= rd_mux_w;
   end

   assign bus_rdata_o = rdata_r;
   assign dac_code_o = trial_r;
   assign converter_power_on_o = converter_power_on_r;
   assign conv_busy_o = state_r == sadc_pkg::SADC_CONV;
   assign irq_o = done_r && done_irq_enable_r;

   // Helper: clock cycles since the last start, saturating
   logic [15:0] age_r;
   always_ff @(posedge clk_i) begin
      if (!nrst_i || start_w) age_r <= 16'h0000;
      else if (age_r != 16'hFFFF) age_r <= age_r + 16'h0001;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   property p_start;
      start_w |=> conv_busy_o && !done_r && dac_code_o == 8'h80;
   endproperty
   a_start: assert property (p_start)
      else $error("trigger did not start a conversion");
   property p_done;
      conv_busy_o && tick_w && last_w && !start_w && !stop_w
         |=> done_r && !conv_busy_o
         && (bus_rdata_o == $past(bus_rdata_o) || $past(bus_rd_i));
   endproperty
   a_done: assert property (p_done)
      else $error("done flag not set at end of conversion");
   property p_no_auto;
      $rose(conv_busy_o) |-> $past(start_w);
   endproperty
   a_no_auto: assert property (p_no_auto)
      else $error("conversion began without a trigger");
   property p_restart;
      start_w && conv_busy_o |=> step_r == 6'h00 && conv_busy_o;
   endproperty
   a_restart: assert property (p_restart)
      else $error("trigger during conversion did not restart");
   property p_rd_trig;
      bus_rd_i && bus_addr_i == sadc_pkg::CTRL_ADDR |=> !bus_rdata_o[5];
   endproperty
   a_rd_trig: assert property (p_rd_trig)
      else $error("trigger bit read back as one");
   property p_irq;
      $rose(done_r) && done_irq_enable_r |-> irq_o;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt missing on done");
   property p_mask;
      !done_irq_enable_r |-> !irq_o;
   endproperty
   a_mask: assert property (p_mask)
      else $error("interrupt raised while masked");
   property p_clear;
      $fell(done_r) |-> $past(ctrl_wr_w && bus_wdata_i[5]);
   endproperty
   a_clear: assert property (p_clear)
      else $error("done cleared without trigger write");
   property p_power;
      conv_busy_o |-> converter_power_on_o;
   endproperty
   a_power: assert property (p_power)
      else $error("converting while powered down");
   property p_duration;
      // Reset also raises done; that edge is not a conversion end
      $rose(done_r) && $past(nrst_i)
         |-> age_r >= 16'(sadc_pkg::CONV_TICKS * 6 - 1)
         && age_r <= 16'(sadc_pkg::CONV_TICKS * 12);
   endproperty
   a_duration: assert property (p_duration)
      else $error("conversion length out of range");
   property p_reset;
      // Own disable, else the default one would mask every attempt
      @(posedge clk_i) disable iff (1'b0)
         !nrst_i |=> !conv_busy_o && done_r && !irq_o;
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset state wrong");

   c_done: cover property ($rose(done_r));
   c_restart: cover property (start_w && conv_busy_o);
   c_irq: cover property ($rose(irq_o));
   c_abort: cover property (stop_w && conv_busy_o);
endmodule // sadc_control
`default_nettype wire

//--- test/sadc_cmp_model.sv
`timescale 1ns/1ns
`default_nettype none
// Behavioural comparator fed by one selected analog level
module sadc_cmp_model (
   input wire logic clk_i,
   input wire logic pwr_i,
   input wire logic [7:0] code_i,
   input wire logic [7:0] vin_i,
   output logic above_o
);
   logic junk_r = 1'b0;
   // Unpowered comparator output means nothing, so it wanders
   always @(posedge clk_i) begin
      junk_r <= ~junk_r;
   end
   // One level only: a single input line is ever selected
   assign above_o = pwr_i ? (vin_i >= code_i) : junk_r;
endmodule // sadc_cmp_model
`default_nettype wire

//--- test/test_sadc_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_sadc_control;
   localparam int FAST = sadc_pkg::CONV_TICKS * sadc_pkg::DIV_FAST;
   localparam int SLOW = sadc_pkg::CONV_TICKS * sadc_pkg::DIV_SLOW;
   localparam logic [7:0] CA = sadc_pkg::CTRL_ADDR;
   localparam logic [7:0] RA = sadc_pkg::RESULT_ADDR;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:0] bus_addr_i = 8'h00;
   logic [7:0] bus_wdata_i = 8'h00;
   logic bus_wr_i = 1'b0;
   logic bus_rd_i = 1'b0;
   logic [7:0] vin = 8'h00;
   logic [7:0] bus_rdata_o, dac_code_o;
   logic cmp_above_i, converter_power_on_o, conv_busy_o, irq_o;
   logic busy_d = 1'b0;
   logic [31:0] seed = 32'h0000D7EF;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int cnt = 0;
   logic [7:0] rd_q[$];
   logic [10:0] cv_q[$];

   always #4 clk_i = ~clk_i;

   sadc_control u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
      .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
      .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o),
      .cmp_above_i(cmp_above_i), .dac_code_o(dac_code_o),
      .converter_power_on_o(converter_power_on_o),
      .conv_busy_o(conv_busy_o), .irq_o(irq_o));
   sadc_cmp_model u_cmp (.clk_i(clk_i), .pwr_i(converter_power_on_o),
      .code_i(dac_code_o), .vin_i(vin), .above_o(cmp_above_i));

   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic note(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("Error at %0t ns: %s", $time, msg);
      end
   endtask
   task automatic chk_rd(input logic [7:0] got, exp);
      note(got === exp, "register read differs");
   endtask
   task automatic chk_conv(input logic [10:0] got, exp);
      note(got === exp, "conversion length or irq differs");
   endtask
   task automatic chk_lvl(input logic got, exp);
      note(got === exp, "output level differs");
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Reserved bits always written as zero
   task automatic wr(input logic [7:0] a, d);
      @(negedge clk_i);
      bus_addr_i <= a;
      bus_wdata_i <= d;
      bus_wr_i <= 1'b1;
      @(negedge clk_i);
      bus_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      @(negedge clk_i);
      rd_q.push_back(exp);
      bus_addr_i <= a;
      bus_rd_i <= 1'b1;
      @(negedge clk_i);
      bus_rd_i <= 1'b0;
   endtask
   // Same tick count for both dividers, so only the divider scales it
   task automatic start(input logic [7:0] d);
      int t;
      t = d[2] ? FAST : SLOW;
      cv_q.push_back({t[9:0], d[7]});
      wr(CA, d);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 700 && conv_busy_o === 1'b1; i++) @(negedge clk_i);
   endtask

   // Watcher: inputs seen here are those taken at the last rising edge
   always @(negedge clk_i) begin
      cnt = (bus_wr_i && bus_addr_i === CA && bus_wdata_i[5]) ? 0 : cnt + 1;
      if (bus_rd_i === 1'b1) chk_rd(bus_rdata_o, rd_q.pop_front());
      if (busy_d && !conv_busy_o && converter_power_on_o === 1'b1) begin
         if (cv_q.size() == 0) note(1'b0, "conversion end not asked for");
         else chk_conv({cnt[9:0], irq_o}, cv_q.pop_front());
      end
      busy_d = conv_busy_o;
   end

   // Hang guard, well above the few thousand cycles the run needs
   always @(posedge clk_i) begin
      cyc++;
      if (cyc >= 10000) begin
         note(1'b0, "timeout");
         wrap_up();
      end
   end

   initial begin
      repeat (2) @(negedge clk_i);
      nrst_i <= 1'b1;
      rd(CA, 8'h40);
      rd(RA, 8'h00);
      chk_lvl(irq_o, 1'b0);
      wr(CA, 8'h10);
      chk_lvl(converter_power_on_o, 1'b1);
      vin <= 8'hA5;
      start(8'h34);
      rd(CA, 8'h14);
      wait_idle();
      rd(CA, 8'h54);
      rd(RA, 8'hA5);
      wr(CA, 8'h14);
      wr(RA, 8'hFF);
      rd(CA, 8'h54);
      rd(RA, 8'hA5);
      rd(8'hD2, 8'h00);
      // Slow divider, interrupt on, then idle long enough to show no restart
      vin <= 8'h00;
      start(8'hB0);
      wait_idle();
      repeat (700) @(negedge clk_i);
      chk_lvl(conv_busy_o, 1'b0);
      chk_lvl(irq_o, 1'b1);
      rd(RA, 8'h00);
      rd(CA, 8'hD0);
      // Retrigger in mid-conversion with a new level
      vin <= 8'hFF;
      wr(CA, 8'h34);
      repeat (100) @(negedge clk_i);
      vin <= 8'h3C;
      start(8'h34);
      wait_idle();
      rd(RA, 8'h3C);
      // Power-off abort leaves done low and the old result
      wr(CA, 8'h34);
      repeat (50) @(negedge clk_i);
      wr(CA, 8'h20);
      chk_lvl(conv_busy_o, 1'b0);
      chk_lvl(converter_power_on_o, 1'b0);
      wr(CA, 8'h40);
      rd(CA, 8'h00);
      rd(RA, 8'h3C);
      wr(CA, 8'h10);
      for (int i = 0; i < 4; i++) begin
         vin <= xs();
         start(8'h34);
         wait_idle();
         rd(RA, vin);
      end
      // Reset in mid-conversion
      wr(CA, 8'h34);
      repeat (30) @(negedge clk_i);
      nrst_i <= 1'b0;
      @(negedge clk_i);
      nrst_i <= 1'b1;
      chk_lvl(conv_busy_o, 1'b0);
      rd(CA, 8'h40);
      repeat (2) @(negedge clk_i);
      wrap_up();
   end
endmodule // test_sadc_control
`default_nettype wire
